// *** design/rwar_params.svh ***
// Timing counts and reset values for the restore window after reset block
`ifndef RWAR_PARAMS_SVH
`define RWAR_PARAMS_SVH
`define RWAR_CLK_HZ          100000000
`define RWAR_WINDOW_S        3
`define RWAR_WINDOW_CYCLES   (`RWAR_WINDOW_S * `RWAR_CLK_HZ)
`define RWAR_DEBOUNCE_US     10000
`define RWAR_DEBOUNCE_CYCLES ((`RWAR_DEBOUNCE_US * (`RWAR_CLK_HZ / 1000000)))
`define RWAR_CNT_W           32
`define RWAR_DB_W            24
`define RWAR_PULSE_RST       1'h0
`endif

// *** design/rwar_pkg.sv ***
// Types for the restore window after reset block
package rwar_pkg;
    typedef enum logic [1:0]
    {
        RWAR_HELD   = 2'h0,
        RWAR_WINDOW = 2'h1,
        RWAR_DONE   = 2'h3
    } rwar_state_t;
endpackage : rwar_pkg

// *** design/rwar_debounce.sv ***
// Debounce filter for an active-low push-button input
`include "rwar_params.svh"
module rwar_debounce
    import rwar_pkg::*;
#(
    parameter logic [`RWAR_DB_W-1:0] STABLE_CYCLES = `RWAR_DB_W'(`RWAR_DEBOUNCE_CYCLES)
)
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic raw_low,
    output logic      pressed
);
    logic [`RWAR_DB_W-1:0] stable_cnt;
    logic                  last_raw;
    wire                   changed = raw_low != last_raw;
    wire                   reached = stable_cnt >= STABLE_CYCLES - `RWAR_DB_W'(1);
    wire [`RWAR_DB_W-1:0]  next_cnt = changed ? '0 : (reached ? stable_cnt : stable_cnt + `RWAR_DB_W'(1));

    // Count cycles the raw level has not moved; idle level is high
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            last_raw   <= 1'h1;
            stable_cnt <= '0;
            pressed    <= 1'h0;
        end
        else
        begin
            last_raw   <= raw_low;
            stable_cnt <= next_cnt;
            if (!changed && reached)
                pressed <= !last_raw;
        end
    end

    a_stable_low: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(pressed) |-> $past(last_raw) == 1'h0)
        else $error("press accepted on a high level");
endmodule // rwar_debounce

// *** design/rwar_top.sv ***
// Restore window after reset: watches the restore button after reset release
`include "rwar_params.svh"
module rwar_top
    import rwar_pkg::*;
#(
    parameter logic [`RWAR_CNT_W-1:0] WINDOW_CYCLES = `RWAR_CNT_W'(`RWAR_WINDOW_CYCLES),
    parameter logic [`RWAR_DB_W-1:0]  DB_CYCLES     = `RWAR_DB_W'(`RWAR_DEBOUNCE_CYCLES)
)
(
    input  wire logic CLOCK,
    input  wire logic RST_N,
    input  wire logic MODULE_RESET_REQUEST_LOW,
    input  wire logic RESTORE_LOW,
    input  wire logic RESTORE_PULLUP_EN_N,
    output logic      RESET_INDICATOR,
    output logic      RESTORE_PULLUP_EN,
    output logic      LOAD_NET_ADDRESS,
    output logic      LOAD_LINK_SETTINGS,
    output logic      LOAD_SERIAL_SETTINGS,
    output logic      LOAD_CREDENTIALS,
    output logic      LOAD_WIRELESS,
    output logic      LOAD_JOIN_KEY,
    output logic      CLEAR_ACCESS_LIST,
    output logic      CLEAR_LOGS,
    output logic      CLEAR_NODE_LIST,
    output logic      CLEAR_UPDATE_FILES,
    output logic      WINDOW_OPEN
);
    rwar_state_t             state;
    rwar_state_t             next_state;
    logic [`RWAR_CNT_W-1:0]  win_cnt;
    logic                    pressed;
    logic                    pressed_d;
    logic                    fire;

    // Pull-up enable has no effect: restore_level is RESTORE_LOW unchanged either way, no forced high
    wire restore_level = RESTORE_PULLUP_EN_N ? RESTORE_LOW : (RESTORE_LOW | 1'h0);
    wire held          = !MODULE_RESET_REQUEST_LOW;
    wire in_window     = state == RWAR_WINDOW;
    wire press_edge    = pressed && !pressed_d;
    wire win_end       = win_cnt >= WINDOW_CYCLES - `RWAR_CNT_W'(1);
    wire next_fire     = in_window && press_edge && !held;

    rwar_debounce #(.STABLE_CYCLES(DB_CYCLES)) u_db
    (
        .clk     (CLOCK),
        .rst_n   (RST_N),
        .raw_low (restore_level),
        .pressed (pressed)
    );

    // Window sequencing; a press held through release must be re-pressed
    // Only a fresh reset request reopens the window, so one restore per window
    // The unused code 2'h2 falls back to the held state as a safe landing
    always_comb
    begin
        next_state = state;
        unique case (state)
            RWAR_HELD:
            begin
                if (!held)
                    next_state = RWAR_WINDOW;
            end
            RWAR_WINDOW:
            begin
                if (held)
                    next_state = RWAR_HELD;
                else if (win_end || fire)
                    next_state = RWAR_DONE;
            end
            RWAR_DONE:
            begin
                if (held)
                    next_state = RWAR_HELD;
            end
            default:
            begin
                next_state = RWAR_HELD;
            end
        endcase
    end

    // State and window counter
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            state     <= RWAR_HELD;
            win_cnt   <= '0;
            pressed_d <= 1'h1;
            fire      <= `RWAR_PULSE_RST;
        end
        else
        begin
            state     <= next_state;
            win_cnt   <= in_window ? win_cnt + `RWAR_CNT_W'(1) : '0;
            pressed_d <= pressed | held;
            fire      <= next_fire;
        end
    end

    // Registered outputs; one pulse drives every default reload
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            RESET_INDICATOR      <= 1'h1;
            RESTORE_PULLUP_EN    <= 1'h1;
            WINDOW_OPEN          <= 1'h0;
            LOAD_NET_ADDRESS     <= 1'h0;
            LOAD_LINK_SETTINGS   <= 1'h0;
            LOAD_SERIAL_SETTINGS <= 1'h0;
            LOAD_CREDENTIALS     <= 1'h0;
            LOAD_WIRELESS        <= 1'h0;
            LOAD_JOIN_KEY        <= 1'h0;
            CLEAR_ACCESS_LIST    <= 1'h0;
            CLEAR_LOGS           <= 1'h0;
            CLEAR_NODE_LIST      <= 1'h0;
            CLEAR_UPDATE_FILES   <= 1'h0;
        end
        else
        begin
            RESET_INDICATOR      <= held;
            RESTORE_PULLUP_EN    <= 1'h1;
            WINDOW_OPEN          <= next_state == RWAR_WINDOW;
            LOAD_NET_ADDRESS     <= next_fire;
            LOAD_LINK_SETTINGS   <= next_fire;
            LOAD_SERIAL_SETTINGS <= next_fire;
            LOAD_CREDENTIALS     <= next_fire;
            LOAD_WIRELESS        <= next_fire;
            LOAD_JOIN_KEY        <= next_fire;
            CLEAR_ACCESS_LIST    <= next_fire;
            CLEAR_LOGS           <= next_fire;
            CLEAR_NODE_LIST      <= next_fire;
            CLEAR_UPDATE_FILES   <= next_fire;
        end
    end

    a_restore_in_window: assert property (@(posedge CLOCK) disable iff (!RST_N)
        $rose(LOAD_NET_ADDRESS) |-> $past(in_window))
        else $error("restore outside window");
    a_no_restore_held: assert property (@(posedge CLOCK) disable iff (!RST_N)
        RESET_INDICATOR |-> !LOAD_NET_ADDRESS)
        else $error("restore while held");
    a_window_length: assert property (@(posedge CLOCK) disable iff (!RST_N)
        in_window |-> win_cnt < WINDOW_CYCLES)
        else $error("window overran");
    a_indicator_follows: assert property (@(posedge CLOCK) disable iff (!RST_N)
        held |=> RESET_INDICATOR)
        else $error("indicator not lit in reset");
    a_indicator_off: assert property (@(posedge CLOCK) disable iff (!RST_N)
        !held |=> !RESET_INDICATOR)
        else $error("indicator lit out of reset");
    a_pullup_on: assert property (@(posedge CLOCK) disable iff (!RST_N)
        RESTORE_PULLUP_EN)
        else $error("pull-up disabled");
    a_all_loads: assert property (@(posedge CLOCK) disable iff (!RST_N)
        LOAD_NET_ADDRESS |-> LOAD_JOIN_KEY && CLEAR_LOGS && CLEAR_NODE_LIST && CLEAR_ACCESS_LIST && LOAD_CREDENTIALS)
        else $error("partial restore");
    a_single_pulse: assert property (@(posedge CLOCK) disable iff (!RST_N)
        LOAD_NET_ADDRESS |=> !LOAD_NET_ADDRESS [*2])
        else $error("restore pulse repeated");
    a_press_cause: assert property (@(posedge CLOCK) disable iff (!RST_N)
        $rose(LOAD_WIRELESS) |-> $past(pressed))
        else $error("restore without debounced press");

    // Window entry and exit follow the request level and the counter
    // These guard the sequencing against a stuck or skipped state
    a_window_opens: assert property (@(posedge CLOCK) disable iff (!RST_N)
        state == RWAR_HELD && !held |=> state == RWAR_WINDOW)
        else $error("window did not open on release");
    a_window_closes: assert property (@(posedge CLOCK) disable iff (!RST_N)
        in_window && win_end && !held |=> state == RWAR_DONE)
        else $error("window did not close at limit");
    a_done_stays: assert property (@(posedge CLOCK) disable iff (!RST_N)
        state == RWAR_DONE && !held |=> state == RWAR_DONE)
        else $error("window reopened without reset");
    a_open_flag: assert property (@(posedge CLOCK) disable iff (!RST_N)
        WINDOW_OPEN == in_window)
        else $error("window flag out of step");

    // Restore pulse only from a fresh debounced edge inside the window
    a_no_fire_outside: assert property (@(posedge CLOCK) disable iff (!RST_N)
        !in_window |=> !LOAD_NET_ADDRESS)
        else $error("restore fired outside window");
    a_no_fire_unpressed: assert property (@(posedge CLOCK) disable iff (!RST_N)
        !press_edge |=> !LOAD_NET_ADDRESS)
        else $error("restore without press edge");
    a_held_press_ignored: assert property (@(posedge CLOCK) disable iff (!RST_N)
        held |=> !press_edge)
        else $error("press held through reset accepted");
    a_full_group: assert property (@(posedge CLOCK) disable iff (!RST_N)
        LOAD_NET_ADDRESS |-> LOAD_LINK_SETTINGS && LOAD_SERIAL_SETTINGS && LOAD_WIRELESS && CLEAR_UPDATE_FILES)
        else $error("reload group incomplete");

    c_restore: cover property (@(posedge CLOCK) disable iff (!RST_N) $rose(LOAD_NET_ADDRESS));
    c_window_expire: cover property (@(posedge CLOCK) disable iff (!RST_N) in_window && win_end && !fire);
    c_reenter_reset: cover property (@(posedge CLOCK) disable iff (!RST_N) in_window ##1 held);
    c_held_press: cover property (@(posedge CLOCK) disable iff (!RST_N) held ##1 (!held && pressed));
endmodule // rwar_top

// *** verif/rwar_button_model.sv ***
// Push button and host reset logic facing the restore block
module rwar_button_model
(
    input  wire logic clk,
    output logic      req_low,
    output logic      restore_low
);
    timeunit 1ns;
    timeprecision 1ns;
    logic closed = 1'h0;
    // Open contact reads high through the pull-up, never a stale level
    assign restore_low = closed ? 1'h0 : 1'h1;
    initial req_low = 1'h1;
    // Contact chatters before settling, as a real switch does
    task automatic press(input int n);
        repeat (3)
        begin
            @(posedge clk) closed <= 1'h1;
            @(posedge clk) closed <= 1'h0;
        end
        @(posedge clk) closed <= 1'h1;
        repeat (n) @(posedge clk);
        closed <= 1'h0;
    endtask
    // Host holds the block in reset for n cycles
    task automatic reset_req(input int n);
        @(posedge clk) req_low <= 1'h0;
        repeat (n) @(posedge clk);
        req_low <= 1'h1;
    endtask
endmodule // rwar_button_model

// *** verif/tb_top.sv ***
// Self-checking bench for the restore window after reset block
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic       CLOCK = 1'h0;
    logic       RST_N = 1'h0;
    logic       req_low, rst_low, ind, pu_en, win;
    logic [9:0] grp;
    int         pulses = 0, miscompares = 0, num_checks = 0, p0;
    rwar_button_model m (.clk(CLOCK), .req_low(req_low), .restore_low(rst_low));
    rwar_top #(.WINDOW_CYCLES(32'h7D0), .DB_CYCLES(24'h8)) dut (.CLOCK(CLOCK), .RST_N(RST_N),
        .MODULE_RESET_REQUEST_LOW(req_low), .RESTORE_LOW(rst_low), .RESTORE_PULLUP_EN_N(1'h0),
        .RESET_INDICATOR(ind), .RESTORE_PULLUP_EN(pu_en), .LOAD_NET_ADDRESS(grp[0]),
        .LOAD_LINK_SETTINGS(grp[1]), .LOAD_SERIAL_SETTINGS(grp[2]), .LOAD_CREDENTIALS(grp[3]),
        .LOAD_WIRELESS(grp[4]), .LOAD_JOIN_KEY(grp[5]), .CLEAR_ACCESS_LIST(grp[6]),
        .CLEAR_LOGS(grp[7]), .CLEAR_NODE_LIST(grp[8]), .CLEAR_UPDATE_FILES(grp[9]), .WINDOW_OPEN(win));
    // Clock at 100 MHz
    initial forever #5 CLOCK = ~CLOCK;
    // All restore actions must fire together; sampled mid-cycle where settled
    always @(negedge CLOCK)
    begin
        if (RST_N)
        begin
            `CHK("action_group", {10{grp[0]}}, grp)
            if (grp[0] === 1'h1) pulses++;
        end
    end
    task automatic end_sim();
        if (miscompares == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Press and expect n actions; bounded wait cuts a hang short
    task automatic press_expect(input int hold, input int n);
        p0 = pulses;
        m.press(hold);
        for (int i = 0; i < 40 && pulses < p0 + n; i++) @(posedge CLOCK);
        repeat (5) @(posedge CLOCK);
        `CHK("action_count", p0 + n, pulses)
    endtask
    task automatic t_reset();
        fork
            m.reset_req(20);
            begin repeat (6) @(posedge CLOCK); #1 `CHK("indicator", 1'h1, ind) end
        join
        repeat (3) @(posedge CLOCK);
        #1 `CHK("indicator_off", 1'h0, ind)
        `CHK("window", 1'h1, win)
        `CHK("pullup", 1'h1, pu_en)
    endtask
    // Short glitches below the stable count must be rejected
    task automatic t_short();
        press_expect(4, 0);
    endtask
    // Bouncy press inside the window gives exactly one restore
    task automatic t_valid();
        press_expect(30, 1);
        `CHK("window_closed", 1'h0, win)
        press_expect(30, 0);
    endtask
    // Press after the window has run out is ignored
    task automatic t_late();
        m.reset_req(10);
        repeat (2100) @(posedge CLOCK);
        `CHK("window_expired", 1'h0, win)
        press_expect(30, 0);
    endtask
    initial
    begin
        repeat (12) @(posedge CLOCK);
        RST_N <= 1'h1;
        repeat (30) @(posedge CLOCK);
        `CHK("idle_no_action", 0, pulses)
        t_reset();
        t_short();
        t_valid();
        t_late();
        end_sim();
    end
endmodule // tb_top
